// ### design/supervision_consts.svh
// Constants for the supply supervision and brake sequencer block.
// Assumes inclusion by bare name from design and bench files.
`ifndef SUPERVISION_CONSTS_SVH
`define SUPERVISION_CONSTS_SVH

// ==========================================================
// Object indices and subindices
`define IDX_OV_THRESHOLD   16'h2034
`define IDX_UV_THRESHOLD   16'h2035
`define IDX_IDLE_TIME      16'h2036
`define IDX_REDUCE_TARGET  16'h2037
`define IDX_BRAKE_TIMING   16'h2038
`define SUB_ENTRY_COUNT    8'h00
`define SUB_CLOSE_IDLE     8'h01
`define SUB_SHUTDOWN_IDLE  8'h02
`define SUB_OPEN_DELAY     8'h03
`define SUB_START_DELAY    8'h04
`define SUB_PWM_FREQ       8'h05
`define SUB_PWM_DUTY       8'h06

// ==========================================================
// Reset values
`define RST_OV_THRESHOLD   32'h0000C20D
`define RST_UV_THRESHOLD   32'h00002710
`define RST_IDLE_TIME      32'h000003E8
`define RST_REDUCE_TARGET  32'h0FFFFFCE
`define RST_CLOSE_IDLE     32'h000003E8
`define RST_SHUTDOWN_IDLE  32'h000003E8
`define RST_OPEN_DELAY     32'h000003E8
`define RST_START_DELAY    32'h00000000
`define RST_PWM_FREQ       32'h00000000
`define RST_PWM_DUTY       32'h00000000
`define ENTRY_COUNT        8'h06

// ==========================================================
// Limits, hysteresis and field positions
`define OV_HYST_MV         32'h000007D0
`define UV_HYST_MV         32'h000005DC
`define PWM_FREQ_MAX       32'h00004E20
`define PWM_DUTY_MIN       32'h00000002
`define PWM_DUTY_MAX       32'h00000064
`define PCT_FULL           7'h64
`define CFG_REDUCE_BIT     3

// ==========================================================
// Timing
`define CLK_HZ             32'h01312D00
`define MS_PER_S           32'h000003E8
`define TICK_MS            32'h00000001
`define CYCLES_PER_MS      (`CLK_HZ / `MS_PER_S * `TICK_MS)
`define PWM_DUTY_STEP      (`CLK_HZ / 32'h00000064)

`endif

// ### design/supervision_pkg.sv
// Types shared by the supervision block and its brake PWM generator.
// Assumes the constants header is compiled alongside.
`default_nettype none

package supervision_pkg;

  // ==========================================================
  // Brake sequencer states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_OPEN_WAIT,
    ST_START_WAIT,
    ST_RUN,
    ST_CLOSE_WAIT,
    ST_SHUT_WAIT
  } brake_state_e;

  // ==========================================================
  // Whole state of the main block
  typedef struct packed {
    logic [31:0]  ov_th;
    logic [31:0]  uv_th;
    logic [31:0]  idle_time;
    logic [31:0]  reduce_target;
    logic [31:0]  close_idle;
    logic [31:0]  shut_idle;
    logic [31:0]  open_delay;
    logic [31:0]  start_delay;
    logic [31:0]  pwm_freq;
    logic [31:0]  pwm_duty;
    brake_state_e state;
    logic [31:0]  seq_ms;
    logic [31:0]  ms_div;
    logic         ms_tick;
    logic [31:0]  idle_ms;
    logic         ov_err;
    logic         uv_err;
    logic         reduced;
    logic [31:0]  limit_ma;
    logic [31:0]  rdata;
    logic         ack;
    logic         refused;
    logic         motor_en;
    logic         op_en;
    logic         brake_rel;
  } main_state_s;

  // ==========================================================
  // State of the PWM generator
  typedef struct packed {
    logic [24:0] phase;
    logic        out;
  } pwm_state_s;

endpackage

`default_nettype wire

// ### design/brake_pwm.sv
// Brake drive PWM generator built on a phase accumulator.
// Assumes frequency and duty were range checked before they reach it.
`include "supervision_consts.svh"
`default_nettype none

module brake_pwm
  import supervision_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        enable_i,
  input  wire logic [31:0] freq_hz_i,
  input  wire logic [31:0] duty_pct_i,
  output logic             pwm_o
);

  pwm_state_s s_r;
  pwm_state_s s_nxt;
  logic [31:0] sum;
  logic [31:0] high_span;

  // ==========================================================
  // Phase accumulator
  // Add frequency, wrap at clock rate: no divider needed
  always_comb begin
    s_nxt     = s_r;
    sum       = 32'(s_r.phase) + freq_hz_i;
    high_span = 32'(duty_pct_i * `PWM_DUTY_STEP);
    if (!enable_i) begin
      s_nxt.phase = 25'h0000000;
      s_nxt.out   = 1'b0;
    end else if (freq_hz_i == 32'h00000000 || duty_pct_i == 32'h00000000) begin
      s_nxt.out = 1'b1; // Steady drive when no PWM is programmed
    end else begin
      s_nxt.phase = (sum >= `CLK_HZ) ? 25'(sum - `CLK_HZ) : 25'(sum);
      s_nxt.out   = 32'(s_nxt.phase) < high_span;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pwm_o = s_r.out;

endmodule

`default_nettype wire

// ### design/supply_supervision_brake_sequencer.sv
// Supply voltage supervision, standstill current reduction and brake sequencing.
// Assumes voltage, standstill and run request come from logic on clk_sys_i.
//
// How it works
// - Over-voltage threshold register, preset, read/write
// - Under-voltage threshold register, preset, read/write
// - Above over-voltage threshold: current off, error
// - Over-voltage error clears below threshold minus 2V
// - Below under-voltage threshold: current off, error
// - Under-voltage error clears above threshold plus 1.5V
// - Reduce only after standstill idle time elapses
// - Reduction needs config bit 3 and standstill
// - Non-negative target below rated: target mA rms
// - Target -1..-100: rated times (target+100)/100
// - Stop: wait close time after standstill, brake
// - After braking wait shutdown time, current off
// - Start: current on, open delay, then release
// - After release wait start delay, operation enabled
// - Four millisecond delays plus PWM settings stored
// - Brake PWM frequency 0 to 20000 Hz
// - Brake PWM duty 0 or 2..100 percent
// - Entry count read-only, reads six
`include "supervision_consts.svh"
`default_nettype none

module supply_supervision_brake_sequencer
  import supervision_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `CYCLES_PER_MS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] obj_index_i,
  input  wire logic [7:0]  obj_sub_i,
  input  wire logic        obj_wr_i,
  input  wire logic        obj_rd_i,
  input  wire logic [31:0] obj_wdata_i,
  output logic [31:0]      obj_rdata_o,
  output logic             obj_ack_o,
  output logic             obj_refused_o,
  input  wire logic [31:0] supply_mv_i,
  input  wire logic [31:0] rated_current_ma_i,
  input  wire logic [31:0] motor_config_i,
  input  wire logic        standstill_i,
  input  wire logic        run_request_i,
  output logic             motor_current_en_o,
  output logic             operation_enabled_o,
  output logic             brake_drive_o,
  output logic             overvoltage_err_o,
  output logic             undervoltage_err_o,
  output logic             current_reduced_o,
  output logic [31:0]      current_limit_ma_o
);

  main_state_s s_r;
  main_state_s s_nxt;
  logic        pwm_out;
  logic        access;
  logic        mapped;
  logic        ro_hit;
  logic        bad_value;
  logic [32:0] ov_clear_lvl;
  logic [32:0] uv_clear_lvl;
  logic        fault;
  logic [31:0] cur_delay;
  logic        delay_done;
  logic        reduce_active;
  logic [6:0]  pct;
  logic [38:0] scaled;

  // ==========================================================
  // Register access decode
  // Mapped: any subindex of the four single indices, or a brake timing subindex that exists
  always_comb begin
    access    = obj_wr_i | obj_rd_i;
    mapped    = 1'b0;
    ro_hit    = 1'b0;
    bad_value = 1'b0;
    unique case (obj_index_i)
      `IDX_OV_THRESHOLD, `IDX_UV_THRESHOLD, `IDX_IDLE_TIME, `IDX_REDUCE_TARGET: begin
        mapped = 1'b1;
      end
      `IDX_BRAKE_TIMING: begin
        mapped = obj_sub_i <= `SUB_PWM_DUTY;
        ro_hit = obj_sub_i == `SUB_ENTRY_COUNT;
        if (obj_sub_i == `SUB_PWM_FREQ) begin
          bad_value = obj_wdata_i > `PWM_FREQ_MAX;
        end
        if (obj_sub_i == `SUB_PWM_DUTY) begin
          bad_value = (obj_wdata_i != 32'h00000000) &&
                      (obj_wdata_i < `PWM_DUTY_MIN || obj_wdata_i > `PWM_DUTY_MAX);
        end
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Hysteresis levels, widened so large values do not wrap
  assign ov_clear_lvl = 33'(supply_mv_i) + 33'(`OV_HYST_MV);
  assign uv_clear_lvl = 33'(s_r.uv_th) + 33'(`UV_HYST_MV);

  // ==========================================================
  // Reduced current arithmetic
  // Low seven bits of a -100..-1 target plus 100 give the remaining percentage
  assign pct    = 7'(s_r.reduce_target[6:0] + `PCT_FULL);
  assign scaled = (39'(rated_current_ma_i) * 39'(pct)) / 39'(`PCT_FULL);

  // Delay that the current sequencer state waits for
  always_comb begin
    unique case (s_r.state)
      ST_OPEN_WAIT:  cur_delay = s_r.open_delay;
      ST_START_WAIT: cur_delay = s_r.start_delay;
      ST_CLOSE_WAIT: cur_delay = s_r.close_idle;
      ST_SHUT_WAIT:  cur_delay = s_r.shut_idle;
      default:       cur_delay = 32'h00000000;
    endcase
  end
  assign delay_done = s_r.seq_ms > cur_delay || cur_delay == 32'h00000000;

  // ==========================================================
  // Next state of the whole block
  always_comb begin
    s_nxt         = s_r;
    fault         = 1'b0;
    reduce_active = 1'b0;
    s_nxt.ack     = access;
    s_nxt.refused = access & (~mapped | (obj_wr_i & (ro_hit | bad_value)));

    // Millisecond timebase from the system clock
    s_nxt.ms_tick = 1'b0;
    if (s_r.ms_div >= 32'(MS_CYCLES - 1)) begin
      s_nxt.ms_div  = 32'h00000000;
      s_nxt.ms_tick = 1'b1;
    end else begin
      s_nxt.ms_div = s_r.ms_div + 32'h00000001;
    end

    // Software writes; refused ones leave the stored value alone
    if (obj_wr_i && mapped && !ro_hit && !bad_value) begin
      unique case (obj_index_i)
        `IDX_OV_THRESHOLD:  s_nxt.ov_th = obj_wdata_i;
        `IDX_UV_THRESHOLD:  s_nxt.uv_th = obj_wdata_i;
        `IDX_IDLE_TIME:     s_nxt.idle_time = obj_wdata_i;
        `IDX_REDUCE_TARGET: s_nxt.reduce_target = obj_wdata_i;
        default: begin
          unique case (obj_sub_i)
            `SUB_CLOSE_IDLE:    s_nxt.close_idle = obj_wdata_i;
            `SUB_SHUTDOWN_IDLE: s_nxt.shut_idle = obj_wdata_i;
            `SUB_OPEN_DELAY:    s_nxt.open_delay = obj_wdata_i;
            `SUB_START_DELAY:   s_nxt.start_delay = obj_wdata_i;
            `SUB_PWM_FREQ:      s_nxt.pwm_freq = obj_wdata_i;
            default:            s_nxt.pwm_duty = obj_wdata_i;
          endcase
        end
      endcase
    end

    // Read data, zero for anything unmapped
    if (obj_rd_i) begin
      s_nxt.rdata = 32'h00000000;
      if (mapped) begin
        unique case (obj_index_i)
          `IDX_OV_THRESHOLD:  s_nxt.rdata = s_r.ov_th;
          `IDX_UV_THRESHOLD:  s_nxt.rdata = s_r.uv_th;
          `IDX_IDLE_TIME:     s_nxt.rdata = s_r.idle_time;
          `IDX_REDUCE_TARGET: s_nxt.rdata = s_r.reduce_target;
          default: begin
            unique case (obj_sub_i)
              `SUB_ENTRY_COUNT:   s_nxt.rdata = {24'h000000, `ENTRY_COUNT};
              `SUB_CLOSE_IDLE:    s_nxt.rdata = s_r.close_idle;
              `SUB_SHUTDOWN_IDLE: s_nxt.rdata = s_r.shut_idle;
              `SUB_OPEN_DELAY:    s_nxt.rdata = s_r.open_delay;
              `SUB_START_DELAY:   s_nxt.rdata = s_r.start_delay;
              `SUB_PWM_FREQ:      s_nxt.rdata = s_r.pwm_freq;
              default:            s_nxt.rdata = s_r.pwm_duty;
            endcase
          end
        endcase
      end
    end

    // Voltage supervision with self-clearing errors
    if (supply_mv_i > s_r.ov_th) begin
      s_nxt.ov_err = 1'b1;
    end else if (ov_clear_lvl < 33'(s_r.ov_th)) begin
      s_nxt.ov_err = 1'b0;
    end
    if (supply_mv_i < s_r.uv_th) begin
      s_nxt.uv_err = 1'b1;
    end else if (33'(supply_mv_i) > uv_clear_lvl) begin
      s_nxt.uv_err = 1'b0;
    end
    fault = s_nxt.ov_err | s_nxt.uv_err;

    // Brake sequencer; a wait ends one tick past its count, never short
    if (s_r.ms_tick && s_r.seq_ms != 32'hFFFFFFFF) begin
      s_nxt.seq_ms = s_r.seq_ms + 32'h00000001;
    end
    if (fault) begin
      s_nxt.state  = ST_OFF;
      s_nxt.seq_ms = 32'h00000000;
    end else begin
      unique case (s_r.state)
        ST_OFF: begin
          s_nxt.seq_ms = 32'h00000000;
          if (run_request_i) begin
            s_nxt.state = ST_OPEN_WAIT;
          end
        end
        ST_OPEN_WAIT, ST_START_WAIT, ST_RUN: begin
          if (!run_request_i) begin
            s_nxt.state  = ST_CLOSE_WAIT;
            s_nxt.seq_ms = 32'h00000000;
          end else if (s_r.state == ST_OPEN_WAIT && delay_done) begin
            s_nxt.state  = ST_START_WAIT;
            s_nxt.seq_ms = 32'h00000000;
          end else if (s_r.state == ST_START_WAIT && delay_done) begin
            s_nxt.state = ST_RUN;
          end
        end
        ST_CLOSE_WAIT: begin
          // Time only runs while the motor stands still
          if (!standstill_i) begin
            s_nxt.seq_ms = 32'h00000000;
          end else if (delay_done) begin
            s_nxt.state  = ST_SHUT_WAIT;
            s_nxt.seq_ms = 32'h00000000;
          end
        end
        ST_SHUT_WAIT: begin
          if (delay_done) begin
            s_nxt.state = ST_OFF;
          end
        end
      endcase
    end
    s_nxt.motor_en  = s_nxt.state != ST_OFF;
    s_nxt.brake_rel = s_nxt.state == ST_START_WAIT || s_nxt.state == ST_RUN ||
                      s_nxt.state == ST_CLOSE_WAIT;
    s_nxt.op_en     = s_nxt.state == ST_RUN;

    // Standstill idle timer for current reduction
    if (!(standstill_i && motor_config_i[`CFG_REDUCE_BIT] && s_r.motor_en)) begin
      s_nxt.idle_ms = 32'h00000000;
    end else if (s_r.ms_tick && s_r.idle_ms != 32'hFFFFFFFF) begin
      s_nxt.idle_ms = s_r.idle_ms + 32'h00000001;
    end
    reduce_active = standstill_i && motor_config_i[`CFG_REDUCE_BIT] && s_r.motor_en &&
                    (s_r.idle_ms > s_r.idle_time || s_r.idle_time == 32'h00000000);
    s_nxt.reduced  = reduce_active;
    s_nxt.limit_ma = rated_current_ma_i;
    if (reduce_active) begin
      if (!s_r.reduce_target[31] && s_r.reduce_target < rated_current_ma_i) begin
        s_nxt.limit_ma = s_r.reduce_target;
      end else if (s_r.reduce_target[31] && $signed(s_r.reduce_target) >= -32'sd100) begin
        s_nxt.limit_ma = 32'(scaled);
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r               <= '0;
      s_r.ov_th         <= `RST_OV_THRESHOLD;
      s_r.uv_th         <= `RST_UV_THRESHOLD;
      s_r.idle_time     <= `RST_IDLE_TIME;
      s_r.reduce_target <= `RST_REDUCE_TARGET;
      s_r.close_idle    <= `RST_CLOSE_IDLE;
      s_r.shut_idle     <= `RST_SHUTDOWN_IDLE;
      s_r.open_delay    <= `RST_OPEN_DELAY;
      s_r.start_delay   <= `RST_START_DELAY;
      s_r.pwm_freq      <= `RST_PWM_FREQ;
      s_r.pwm_duty      <= `RST_PWM_DUTY;
      s_r.state         <= ST_OFF;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // Brake PWM, active only while the brake is released
  brake_pwm u_brake_pwm (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .enable_i   (s_nxt.brake_rel),
    .freq_hz_i  (s_r.pwm_freq),
    .duty_pct_i (s_r.pwm_duty),
    .pwm_o      (pwm_out)
  );

  // Outputs
  assign obj_rdata_o         = s_r.rdata;
  assign obj_ack_o           = s_r.ack;
  assign obj_refused_o       = s_r.refused;
  assign motor_current_en_o  = s_r.motor_en;
  assign operation_enabled_o = s_r.op_en;
  assign brake_drive_o       = pwm_out;
  assign overvoltage_err_o   = s_r.ov_err;
  assign undervoltage_err_o  = s_r.uv_err;
  assign current_reduced_o   = s_r.reduced;
  assign current_limit_ma_o  = s_r.limit_ma;

endmodule

`default_nettype wire

// ### tb/sup_checker.sv
// Port assertions for the supervision and brake sequencer block.
// Assumes it is bound onto the block; one clock domain only.
`include "supervision_consts.svh"
`default_nettype none

module sup_checker
  import supervision_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] obj_index_i,
  input wire logic [7:0]  obj_sub_i,
  input wire logic        obj_wr_i,
  input wire logic        obj_rd_i,
  input wire logic [31:0] obj_wdata_i,
  input wire logic        obj_ack_o,
  input wire logic        obj_refused_o,
  input wire logic [31:0] motor_config_i,
  input wire logic        standstill_i,
  input wire logic        motor_current_en_o,
  input wire logic        operation_enabled_o,
  input wire logic        brake_drive_o,
  input wire logic        overvoltage_err_o,
  input wire logic        undervoltage_err_o,
  input wire logic        current_reduced_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Write sequences on the brake timing array
  sequence s_brake_wr(s);
    obj_wr_i && obj_index_i == `IDX_BRAKE_TIMING && obj_sub_i == s;
  endsequence
  sequence s_bad_freq;
    s_brake_wr(`SUB_PWM_FREQ) ##0 obj_wdata_i > `PWM_FREQ_MAX;
  endsequence
  // Duty 1 lies in the gap below 2
  sequence s_bad_duty;
    s_brake_wr(`SUB_PWM_DUTY) ##0 (obj_wdata_i == 32'h00000001 || obj_wdata_i > `PWM_DUTY_MAX);
  endsequence

  // ==========================================================
  // Register access
  a_ack_exact: assert property (obj_ack_o == $past(obj_wr_i | obj_rd_i))
    else $error("ack timing");
  a_refuse_ack: assert property (obj_refused_o |-> obj_ack_o)
    else $error("refusal without ack");
  a_count_ro: assert property (s_brake_wr(`SUB_ENTRY_COUNT) |=> obj_refused_o)
    else $error("entry count write accepted");
  a_freq_refuse: assert property (s_bad_freq |=> obj_refused_o)
    else $error("bad frequency accepted");
  a_duty_refuse: assert property (s_bad_duty |=> obj_refused_o)
    else $error("bad duty accepted");

  // ==========================================================
  // Supervision, sequencing and reduction
  a_ov_off: assert property (overvoltage_err_o |-> !motor_current_en_o && !brake_drive_o)
    else $error("current on in OV");
  a_uv_off: assert property (undervoltage_err_o |-> !motor_current_en_o)
    else $error("current on in UV");
  a_start_order: assert property ($rose(motor_current_en_o) |-> !brake_drive_o && !operation_enabled_o)
    else $error("brake released with current");
  a_op_current: assert property ($rose(operation_enabled_o) |-> motor_current_en_o)
    else $error("operation without current");
  a_brake_first: assert property ($fell(motor_current_en_o) && !overvoltage_err_o && !undervoltage_err_o
    |-> $past(!brake_drive_o))
    else $error("current off before brake");
  a_reduce_cond: assert property (current_reduced_o |-> $past(motor_config_i[3] && standstill_i))
    else $error("reduction not allowed");
endmodule

bind supply_supervision_brake_sequencer sup_checker u_chk (.*);

`default_nettype wire

// ### tb/motor_stage_model.sv
// Model of power stage, motor shaft and supply monitor.
// Assumes the bench sets the supply level and the spin command.
`default_nettype none

module motor_stage_model (
  input  wire logic        clk_sys_i,
  input  wire logic        motor_current_en_i,
  input  wire logic        spin_i,
  input  wire logic [31:0] supply_set_i,
  output logic             standstill_o,
  output logic [31:0]      supply_mv_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Shaft turns only when powered; supply lags a cycle
  always @(posedge clk_sys_i) begin
    standstill_o <= !(spin_i && motor_current_en_i);
    supply_mv_o  <= supply_set_i;
  end
endmodule

`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the supervision and brake sequencer block.
// Assumes design files, stage model and checker are compiled first.
`include "supervision_consts.svh"
`default_nettype none

module tb
  import supervision_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned MS = 20;
  localparam logic [15:0] BT = `IDX_BRAKE_TIMING;
  logic        clk_sys    = 1'b0;
  logic        rst_n      = 1'b0;
  logic [15:0] idx        = 16'h0000;
  logic [7:0]  sub        = 8'h00;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [31:0] wdata      = 32'h00000000;
  logic [31:0] supply_set = 32'h00005DC0;
  logic [31:0] rated      = 32'h00001068;
  logic [31:0] cfg        = 32'h00000000;
  logic        spin       = 1'b0;
  logic        run        = 1'b0;
  logic [31:0] rdata, lim, supply;
  logic        ack, refd, men, op, brk, ove, uve, red, still;
  int          err_total  = 0;
  int          cmp_count  = 0;

  supply_supervision_brake_sequencer #(.MS_CYCLES(MS)) uut (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .obj_index_i(idx), .obj_sub_i(sub), .obj_wr_i(wr),
    .obj_rd_i(rd), .obj_wdata_i(wdata), .obj_rdata_o(rdata), .obj_ack_o(ack), .obj_refused_o(refd),
    .supply_mv_i(supply), .rated_current_ma_i(rated), .motor_config_i(cfg), .standstill_i(still),
    .run_request_i(run), .motor_current_en_o(men), .operation_enabled_o(op), .brake_drive_o(brk),
    .overvoltage_err_o(ove), .undervoltage_err_o(uve), .current_reduced_o(red), .current_limit_ma_o(lim));
  motor_stage_model stage (.clk_sys_i(clk_sys), .motor_current_en_i(men), .spin_i(spin),
    .supply_set_i(supply_set), .standstill_o(still), .supply_mv_o(supply));

  // ==========================================================
  // Clock and shared tasks
  always #25 clk_sys = ~clk_sys;

  // Inputs move 5 ns after the edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One strobe; ack stands one cycle
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                     input logic rf, output logic [31:0] q);
    wr = w;
    rd = !w;
    idx = i;
    sub = s;
    wdata = d;
    tick;
    wr = 1'b0;
    rd = 1'b0;
    check(32'(ack), 32'h1);
    check(32'(refd), 32'(rf));
    q = rdata;
    tick;
  endtask

  task automatic wr32(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic rf);
    logic [31:0] q;
    acc(1'b1, i, s, d, rf, q);
  endtask

  task automatic rdchk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e, input logic rf);
    logic [31:0] q;
    acc(1'b0, i, s, 32'h00000000, rf, q);
    check(q, e);
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return men;
      1: return brk;
      2: return op;
      default: return red;
    endcase
  endfunction

  // Bounded wait; n counts cycles
  task automatic waitfor(input int s, input logic v, input int mx, output int n);
    n = 0;
    while (sig(s) !== v && n < mx) begin
      tick;
      n++;
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_presets;
    logic [31:0] pre [1:6] = '{`RST_CLOSE_IDLE, `RST_SHUTDOWN_IDLE, `RST_OPEN_DELAY, `RST_START_DELAY,
                               `RST_PWM_FREQ, `RST_PWM_DUTY};
    rdchk(`IDX_OV_THRESHOLD, 8'h00, `RST_OV_THRESHOLD, 1'b0);
    rdchk(`IDX_UV_THRESHOLD, 8'h00, `RST_UV_THRESHOLD, 1'b0);
    rdchk(`IDX_IDLE_TIME, 8'h00, `RST_IDLE_TIME, 1'b0);
    rdchk(`IDX_REDUCE_TARGET, 8'h00, `RST_REDUCE_TARGET, 1'b0);
    rdchk(BT, `SUB_ENTRY_COUNT, 32'h00000006, 1'b0);
    for (int k = 1; k <= 6; k++) rdchk(BT, 8'(k), pre[k], 1'b0);
    rdchk(16'h2039, 8'h00, 32'h00000000, 1'b1);
  endtask

  task automatic t_regs;
    logic [31:0] dv [5] = '{32'h00000000, 32'h00000001, 32'h00000002, 32'h00000064, 32'h00000065};
    logic [31:0] de [5] = '{32'h00000000, 32'h00000000, 32'h00000002, 32'h00000064, 32'h00000064};
    wr32(`IDX_OV_THRESHOLD, 8'h00, 32'h0000C350, 1'b0);
    rdchk(`IDX_OV_THRESHOLD, 8'h00, 32'h0000C350, 1'b0);
    wr32(`IDX_UV_THRESHOLD, 8'h00, 32'h00002EE0, 1'b0);
    rdchk(`IDX_UV_THRESHOLD, 8'h00, 32'h00002EE0, 1'b0);
    wr32(BT, `SUB_ENTRY_COUNT, 32'h00000009, 1'b1);
    rdchk(BT, `SUB_ENTRY_COUNT, 32'h00000006, 1'b0);
    wr32(BT, `SUB_PWM_FREQ, 32'h00004E20, 1'b0);
    wr32(BT, `SUB_PWM_FREQ, 32'h00004E21, 1'b1);
    rdchk(BT, `SUB_PWM_FREQ, 32'h00004E20, 1'b0);
    for (int k = 0; k < 5; k++) begin
      wr32(BT, `SUB_PWM_DUTY, dv[k], dv[k] != de[k]);
      rdchk(BT, `SUB_PWM_DUTY, de[k], 1'b0);
    end
    wr32(BT, `SUB_PWM_DUTY, 32'h00000000, 1'b0);
    wr32(BT, `SUB_PWM_FREQ, 32'h00000000, 1'b0);
  endtask

  task automatic t_seq;
    int n;
    for (int k = 1; k <= 4; k++) wr32(BT, 8'(k), 32'(k + 1), 1'b0);
    run = 1'b1;
    tick;
    check(32'(men), 32'h1);
    check(32'(brk), 32'h0);
    waitfor(1, 1'b1, 400, n);
    check(32'(n >= 4 * MS - 1 && n <= 5 * MS + 2), 32'h1);
    waitfor(2, 1'b1, 400, n);
    check(32'(n >= 5 * MS - 1 && n <= 6 * MS + 2), 32'h1);
    run = 1'b0;
    waitfor(1, 1'b0, 400, n);
    check(32'(n >= 2 * MS - 1 && n <= 3 * MS + 2), 32'h1);
    check(32'(men), 32'h1);
    waitfor(0, 1'b0, 400, n);
    check(32'(n >= 3 * MS - 1 && n <= 4 * MS + 2), 32'h1);
  endtask

  task automatic t_supply;
    int n;
    for (int k = 1; k <= 4; k++) wr32(BT, 8'(k), 32'h00000000, 1'b0);
    run = 1'b1;
    waitfor(2, 1'b1, 200, n);
    supply_set = 32'h0000C350;
    tick(4);
    check(32'(ove), 32'h0);
    supply_set = 32'h0000C351;
    tick(3);
    check({ove, men, brk}, 32'h4);
    supply_set = 32'h0000BB80;
    tick(4);
    check(32'(ove), 32'h1);
    supply_set = 32'h0000BB7F;
    tick(3);
    check(32'(ove), 32'h0);
    supply_set = 32'h00002EDF;
    tick(8);
    check({uve, men}, 32'h2);
    supply_set = 32'h000034BC;
    tick(4);
    check(32'(uve), 32'h1);
    supply_set = 32'h000034BD;
    tick(3);
    check(32'(uve), 32'h0);
    supply_set = 32'h00005DC0;
    run = 1'b0;
    waitfor(0, 1'b0, 200, n);
  endtask

  task automatic t_reduce;
    int n;
    wr32(`IDX_IDLE_TIME, 8'h00, 32'h00000003, 1'b0);
    wr32(`IDX_REDUCE_TARGET, 8'h00, 32'hFFFFFFC4, 1'b0);
    cfg = 32'h00000008;
    run = 1'b1;
    waitfor(0, 1'b1, 50, n);
    waitfor(3, 1'b1, 400, n);
    check(32'(n >= 3 * MS - 1 && n <= 4 * MS + 3), 32'h1);
    check(lim, 32'h00000690);
    spin = 1'b1;
    tick(3);
    check(32'(red), 32'h0);
    spin = 1'b0;
    wr32(`IDX_REDUCE_TARGET, 8'h00, 32'h000003E8, 1'b0);
    waitfor(3, 1'b1, 400, n);
    tick;
    check(lim, 32'h000003E8);
    wr32(`IDX_REDUCE_TARGET, 8'h00, 32'hFFFFFF9C, 1'b0);
    tick(2);
    check(lim, 32'h00000000);
    cfg = 32'h00000000;
    tick(3);
    check(32'(red), 32'h0);
    run = 1'b0;
    waitfor(0, 1'b0, 400, n);
  endtask

  // 2000 cycles are two 20 kHz periods
  task automatic t_pwm;
    int n;
    int hi;
    int d [2] = '{25, 2};
    wr32(BT, `SUB_PWM_FREQ, 32'h00004E20, 1'b0);
    for (int k = 0; k < 2; k++) begin
      wr32(BT, `SUB_PWM_DUTY, 32'(d[k]), 1'b0);
      run = 1'b1;
      waitfor(2, 1'b1, 200, n);
      hi = 0;
      repeat (2000) begin
        tick;
        hi += int'(brk === 1'b1);
      end
      check(32'(hi >= 20 * d[k] - 4 && hi <= 20 * d[k] + 4), 32'h1);
      check(32'(hi > 0 && hi < 2000), 32'h1);
      run = 1'b0;
      waitfor(0, 1'b0, 200, n);
    end
  endtask

  // ==========================================================
  // Verdict, main sequence and watchdog
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    tick(16);
    rst_n = 1'b1;
    tick;
    t_presets;
    t_regs;
    t_seq;
    t_supply;
    t_reduce;
    t_pwm;
    end_of_test;
  end

  // Far above the run's length; catches a hang
  initial begin
    tick(60000);
    err_total++;
    end_of_test;
  end
endmodule

`default_nettype wire
